// ==== shared/mcj_defines.svh ====
`ifndef MCJ_DEFINES_SVH
`define MCJ_DEFINES_SVH

// =============================================================
// Relative jump on core identity
`define MCJ_REL_OPC        10'h0BD
`define MCJ_REL_OPC_HI     15
`define MCJ_REL_OPC_LO     6
`define MCJ_REL_SEL_BIT    5
`define MCJ_REL_DISP_HI    4
`define MCJ_REL_DISP_LO    0
`define MCJ_DISP_W         5

// =============================================================
// Absolute jump on start pattern
`define MCJ_ABS_OPC_H      5'h07
`define MCJ_ABS_OPC_H_HI   15
`define MCJ_ABS_OPC_H_LO   11
`define MCJ_ABS_SEL_HI     10
`define MCJ_ABS_SEL_LO     5
`define MCJ_ABS_REG_BIT    4
`define MCJ_ABS_OPC_L      4'h1
`define MCJ_ABS_OPC_L_HI   3
`define MCJ_ABS_OPC_L_LO   0

// =============================================================
// Counter
`define MCJ_PC_STEP        1
`define MCJ_NUM_JREGS      2
`endif

// ==== shared/mcj_pkg.sv ====
package mcj_pkg;
    // Which of the two handled jumps an instruction word is
    typedef enum logic [1:0] {
        MCJ_KIND_NONE,
        MCJ_KIND_REL,
        MCJ_KIND_ABS
    } mcj_kind_t;
endpackage : mcj_pkg

// ==== logic/mcj_jump_regs.sv ====
`timescale 1ns/1ps
`include "mcj_defines.svh"
module mcj_jump_regs #(
    parameter int PC_W = 10
) (
    // Clock and reset
    input  wire logic                                 mclk,
    input  wire logic                                 arst_n,
    // Write port
    input  wire logic                                 wr_en,
    input  wire logic                                 wr_sel,
    input  wire logic [PC_W-1:0]                      wr_data,
    // Stored contents, straight from the flops
    output logic      [`MCJ_NUM_JREGS-1:0][PC_W-1:0]  rd_data
);
    logic [`MCJ_NUM_JREGS-1:0][PC_W-1:0] mem_q;
    logic [`MCJ_NUM_JREGS-1:0][PC_W-1:0] mem_d;

    always_comb begin
        mem_d = mem_q;
        if (wr_en) begin
            mem_d[wr_sel] = wr_data;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mem_q <= '0;
        end else begin
            mem_q <= mem_d;
        end
    end

    assign rd_data = mem_q;
endmodule : mcj_jump_regs

// ==== logic/mcj_cond_jump.sv ====
`timescale 1ns/1ps
`include "mcj_defines.svh"
module mcj_cond_jump #(
    parameter int PC_W       = 10,
    parameter int NUM_STARTS = 6
) (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   arst_n,
    // Instruction from fetch
    input  wire logic                   instr_valid,
    input  wire logic [15:0]            instr_word,
    input  wire logic [PC_W-1:0]        instr_addr,
    // Execution context
    input  wire logic                   core_id,
    input  wire logic [NUM_STARTS-1:0]  start_latched,
    // Jump register loading
    input  wire logic                   jreg_wr_en,
    input  wire logic                   jreg_wr_sel,
    input  wire logic [PC_W-1:0]        jreg_wr_data,
    // Result to the sequencer
    output logic                        pc_valid,
    output logic [PC_W-1:0]             program_counter,
    output logic                        jump_taken,
    output logic                        decoded
);
    // =============================================================
    // Jump register subset
    logic [`MCJ_NUM_JREGS-1:0][PC_W-1:0] jreg_val;

    mcj_jump_regs #(
        .PC_W    (PC_W)
    ) u_jregs (
        .mclk    (mclk),
        .arst_n  (arst_n),
        .wr_en   (jreg_wr_en),
        .wr_sel  (jreg_wr_sel),
        .wr_data (jreg_wr_data),
        .rd_data (jreg_val)
    );

    // =============================================================
    // Decode
    mcj_pkg::mcj_kind_t      kind;
    logic                    core_identity_selector;
    logic [`MCJ_DISP_W-1:0]  disp;
    logic [NUM_STARTS-1:0]   start_pattern_selector;
    logic                    jump_register_operand;
    logic [NUM_STARTS-1:0]   start_bit_ok;
    logic                    core_zero_selected;
    logic                    core_one_selected;
    logic                    rel_cond;
    logic                    abs_cond;
    logic [PC_W-1:0]         disp_ext;
    logic [PC_W-1:0]         seq_pc;

    assign core_identity_selector = instr_word[`MCJ_REL_SEL_BIT];
    assign disp                   = instr_word[`MCJ_REL_DISP_HI:`MCJ_REL_DISP_LO];
    assign start_pattern_selector = instr_word[`MCJ_ABS_SEL_HI:`MCJ_ABS_SEL_LO];
    assign jump_register_operand  = instr_word[`MCJ_ABS_REG_BIT];

    always_comb begin
        kind = mcj_pkg::MCJ_KIND_NONE;
        if (instr_word[`MCJ_REL_OPC_HI:`MCJ_REL_OPC_LO] == `MCJ_REL_OPC) begin
            kind = mcj_pkg::MCJ_KIND_REL;
        end else if (instr_word[`MCJ_ABS_OPC_H_HI:`MCJ_ABS_OPC_H_LO] == `MCJ_ABS_OPC_H
                  && instr_word[`MCJ_ABS_OPC_L_HI:`MCJ_ABS_OPC_L_LO] == `MCJ_ABS_OPC_L) begin
            kind = mcj_pkg::MCJ_KIND_ABS;
        end
    end

    // Exact pattern match: unlatched starts must be clear as well
    genvar gi;
    generate
        for (gi = 0; gi < NUM_STARTS; gi++) begin : g_start
            assign start_bit_ok[gi] = (start_latched[gi] == start_pattern_selector[gi]);
        end
    endgenerate

    assign core_zero_selected = (core_identity_selector == 1'b0) && (core_id == 1'b0);
    assign core_one_selected  = (core_identity_selector == 1'b1) && (core_id == 1'b1);
    assign rel_cond = core_zero_selected || core_one_selected;
    assign abs_cond = &start_bit_ok;

    // Sign extension of the displacement; sum wraps modulo code size
    assign disp_ext = PC_W'({{(PC_W-`MCJ_DISP_W){disp[`MCJ_DISP_W-1]}}, disp});
    assign seq_pc   = instr_addr + PC_W'(`MCJ_PC_STEP);

    // =============================================================
    // Next counter
    logic             pc_valid_q;
    logic             pc_valid_d;
    logic [PC_W-1:0]  pc_q;
    logic [PC_W-1:0]  pc_d;
    logic             taken_q;
    logic             taken_d;
    logic             decoded_q;
    logic             decoded_d;

    always_comb begin
        pc_valid_d = 1'b0;
        pc_d       = pc_q;
        taken_d    = 1'b0;
        decoded_d  = 1'b0;
        if (instr_valid) begin
            case (kind)
                mcj_pkg::MCJ_KIND_REL: begin
                    pc_valid_d = 1'b1;
                    decoded_d  = 1'b1;
                    taken_d    = rel_cond;
                    pc_d       = rel_cond ? instr_addr + disp_ext : seq_pc;
                end
                mcj_pkg::MCJ_KIND_ABS: begin
                    pc_valid_d = 1'b1;
                    decoded_d  = 1'b1;
                    taken_d    = abs_cond;
                    // The one-bit operand can only address the subset
                    pc_d       = abs_cond ? jreg_val[jump_register_operand] : seq_pc;
                end
                default: begin
                    // Other opcodes belong to other decoders; hold the counter
                    pc_d = pc_q;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pc_valid_q <= 1'b0;
            pc_q       <= '0;
            taken_q    <= 1'b0;
            decoded_q  <= 1'b0;
        end else begin
            pc_valid_q <= pc_valid_d;
            pc_q       <= pc_d;
            taken_q    <= taken_d;
            decoded_q  <= decoded_d;
        end
    end

    assign pc_valid        = pc_valid_q;
    assign program_counter = pc_q;
    assign jump_taken      = taken_q;
    assign decoded         = decoded_q;

    // =============================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence s_rel_issue;
        instr_valid && instr_word[15:6] == 10'h0BD;
    endsequence

    sequence s_abs_issue;
        instr_valid && instr_word[15:11] == 5'h07 && instr_word[3:0] == 4'h1;
    endsequence

    a_rel_taken_target: assert property (
        s_rel_issue ##0 (instr_word[5] == core_id) |=>
            program_counter == PC_W'($past(instr_addr)
                + PC_W'({{(PC_W-5){$past(instr_word[4])}}, $past(instr_word[4:0])})))
        else $error("relative jump target wrong");

    a_disp_neg_range: assert property (
        s_rel_issue ##0 (instr_word[5] == core_id) ##0 instr_word[4:0] == 5'h10 |=>
            program_counter == PC_W'($past(instr_addr) - PC_W'(5'h10)))
        else $error("displacement -16 not applied");

    a_core_sel_match: assert property (
        s_rel_issue |=> jump_taken == ($past(instr_word[5]) == $past(core_id)))
        else $error("core identity condition wrong");

    a_rel_decode_hit: assert property (
        s_rel_issue |=> decoded && pc_valid)
        else $error("relative jump not decoded");

    a_abs_taken_target: assert property (
        s_abs_issue ##0 (start_latched == instr_word[10:5]) |=>
            jump_taken && program_counter == $past(jreg_val[instr_word[4]]))
        else $error("absolute jump target wrong");

    a_abs_reg_subset: assert property (
        s_abs_issue ##0 (start_latched == instr_word[10:5]) ##0 instr_word[4] |=>
            program_counter == $past(jreg_val[1]))
        else $error("jump register operand ignored");

    a_start_pattern_eq: assert property (
        s_abs_issue |=> jump_taken == ($past(start_latched) == $past(instr_word[10:5])))
        else $error("start pattern condition wrong");

    a_abs_decode_hit: assert property (
        s_abs_issue |=> decoded && pc_valid)
        else $error("absolute jump not decoded");

    a_not_taken_step: assert property (
        pc_valid && !jump_taken |->
            program_counter == PC_W'($past(instr_addr) + PC_W'(`MCJ_PC_STEP)))
        else $error("fall-through counter wrong");

    a_other_holds: assert property (
        !instr_valid |=> !pc_valid && $stable(program_counter))
        else $error("counter moved without instruction");

    // A pulse with no word behind it would let the sequencer fetch from a stale counter
    a_pulse_has_word: assert property (
        pc_valid |-> decoded && $past(instr_valid))
        else $error("result pulse without instruction");

    a_taken_needs_pulse: assert property (
        jump_taken |-> pc_valid)
        else $error("taken flag outside result pulse");

    a_rel_disp_max: assert property (
        s_rel_issue ##0 (instr_word[5] == core_id) ##0 instr_word[4:0] == 5'h0F |=>
            program_counter == PC_W'($past(instr_addr) + PC_W'(5'h0F)))
        else $error("displacement +15 not applied");

    a_foreign_ignored: assert property (
        instr_valid && instr_word[15:6] != 10'h0BD
            && !(instr_word[15:11] == 5'h07 && instr_word[3:0] == 4'h1) |=>
            !decoded && $stable(program_counter))
        else $error("foreign opcode changed the counter");
endmodule : mcj_cond_jump

// ==== bench/mcj_fetch_model.sv ====
`timescale 1ns/1ps
// ==========================================
// Fetch side: one instruction word per request
module mcj_fetch_model (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Request from the bench
    input  wire logic        req,
    input  wire logic [15:0] req_word,
    input  wire logic [9:0]  req_addr,
    // Toward the decoder
    output logic             instr_valid,
    output logic [15:0]      instr_word,
    output logic [9:0]       instr_addr
);
    // Idle cycles invert the word each edge, so the last fresh value comes back on every second idle cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            instr_valid <= 1'b0;
            instr_word  <= 16'h0000;
            instr_addr  <= 10'h000;
        end else begin
            instr_valid <= req;
            instr_word  <= req ? req_word : ~instr_word;
            instr_addr  <= req ? req_addr : ~instr_addr;
        end
    end
endmodule : mcj_fetch_model

// ==== bench/mcj_cond_jump_test.sv ====
`timescale 1ns/1ps
// ==========================================
// Row table, then hand-written edge cases
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module mcj_cond_jump_test;
    typedef struct packed {
        logic [15:0] w;
        logic [9:0]  a;
        logic        c;
        logic [5:0]  s;
        logic        tk;
        logic [9:0]  pc;
    } mcj_row_t;
    logic mclk = 1'b0, arst_n = 1'b0, req = 1'b0, core_id = 1'b0;
    logic jreg_wr_en = 1'b0, jreg_wr_sel = 1'b0;
    logic [15:0] req_word = 16'h0000, instr_word;
    logic [9:0] req_addr = 10'h000, instr_addr, jreg_wr_data = 10'h000, program_counter;
    logic [5:0] start_latched = 6'h00;
    logic instr_valid, pc_valid, jump_taken, decoded;
    int errors = 0, total_checks = 0;
    mcj_row_t rows [9] = '{
        '{16'h2F4F, 10'h064, 1'b0, 6'h00, 1'b1, 10'h073},
        '{16'h2F6F, 10'h064, 1'b0, 6'h00, 1'b0, 10'h065},
        '{16'h2F70, 10'h005, 1'b1, 6'h00, 1'b1, 10'h3F5},
        '{16'h2F5F, 10'h000, 1'b1, 6'h00, 1'b0, 10'h001},
        '{16'h2F5F, 10'h000, 1'b0, 6'h00, 1'b1, 10'h3FF},
        '{16'h3801, 10'h032, 1'b0, 6'h00, 1'b1, 10'h2AA},
        '{16'h3FF1, 10'h032, 1'b1, 6'h3F, 1'b1, 10'h155},
        '{16'h38A1, 10'h0C8, 1'b0, 6'h04, 1'b0, 10'h0C9},
        '{16'h3C01, 10'h007, 1'b0, 6'h20, 1'b1, 10'h2AA}};
    always #12.5 mclk = ~mclk;
    mcj_fetch_model fm_u (.mclk(mclk), .arst_n(arst_n), .req(req), .req_word(req_word),
        .req_addr(req_addr), .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_addr(instr_addr));
    mcj_cond_jump dut_u (.mclk(mclk), .arst_n(arst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_addr(instr_addr), .core_id(core_id),
        .start_latched(start_latched), .jreg_wr_en(jreg_wr_en), .jreg_wr_sel(jreg_wr_sel),
        .jreg_wr_data(jreg_wr_data), .pc_valid(pc_valid), .program_counter(program_counter),
        .jump_taken(jump_taken), .decoded(decoded));
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // Word reaches the decoder one edge after the request, result one edge later
    task automatic run(input mcj_row_t r);
        @(posedge mclk);
        req <= 1'b1;
        req_word <= r.w;
        req_addr <= r.a;
        core_id <= r.c;
        start_latched <= r.s;
        @(posedge mclk);
        req <= 1'b0;
        @(posedge mclk);
        #1;
    endtask : run
    task automatic wr_jreg(input logic sel, input logic [9:0] d);
        @(posedge mclk);
        jreg_wr_en <= 1'b1;
        jreg_wr_sel <= sel;
        jreg_wr_data <= d;
        @(posedge mclk);
        jreg_wr_en <= 1'b0;
    endtask : wr_jreg
    initial begin
        #50000;
        errors++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        #1;
        `CHK({pc_valid, decoded, jump_taken, program_counter}, 13'h0000)
        wr_jreg(1'b0, 10'h2AA);
        wr_jreg(1'b1, 10'h155);
        foreach (rows[i]) begin
            run(rows[i]);
            `CHK(decoded, 1'b1)
            `CHK(pc_valid, 1'b1)
            `CHK(jump_taken, rows[i].tk)
            `CHK(program_counter, rows[i].pc)
            @(posedge mclk);
            #1;
            `CHK(pc_valid, 1'b0)
            `CHK({decoded, jump_taken}, 2'h0)
        end
        // Near-miss opcodes must be ignored and leave the counter alone
        run('{16'h2F00, 10'h009, 1'b0, 6'h00, 1'b0, 10'h000});
        `CHK({decoded, program_counter}, 11'h2AA)
        run('{16'h3802, 10'h009, 1'b0, 6'h00, 1'b0, 10'h000});
        `CHK({decoded, program_counter}, 11'h2AA)
        // Write landing on the jump edge: old value is used, new one next time
        @(posedge mclk);
        req <= 1'b1;
        req_word <= 16'h3801;
        start_latched <= 6'h00;
        @(posedge mclk);
        req <= 1'b0;
        jreg_wr_en <= 1'b1;
        jreg_wr_data <= 10'h0F0;
        jreg_wr_sel <= 1'b0;
        @(posedge mclk);
        jreg_wr_en <= 1'b0;
        #1;
        `CHK(program_counter, 10'h2AA)
        run(rows[5]);
        `CHK(program_counter, 10'h0F0)
        arst_n <= 1'b0;
        #1;
        `CHK({pc_valid, program_counter}, 11'h000)
        // Reset clears the jump registers, so a taken jump lands on zero
        @(posedge mclk);
        arst_n <= 1'b1;
        run(rows[5]);
        `CHK({pc_valid, jump_taken, program_counter}, 12'hC00)
        conclude();
    end
endmodule : mcj_cond_jump_test
